/* File: uef_consts.svh */
`ifndef UEF_CONSTS_SVH
`define UEF_CONSTS_SVH

// Register offsets inside one UART channel.
`define UEF_OFS_SPCL_FLAGS 8'h06
`define UEF_OFS_SPCL_EN 8'h05
`define UEF_OFS_STS_EN 8'h07
`define UEF_OFS_STS_FLAGS 8'h08
`define UEF_OFS_MODE_CONTROL_ONE 8'h09
`define UEF_OFS_MODE_CONTROL_TWO 8'h0A

// Special-character event flag positions.
`define UEF_BIT_RESUME1 0
`define UEF_BIT_RESUME2 1
`define UEF_BIT_PAUSE1 2
`define UEF_BIT_PAUSE2 3
`define UEF_BIT_BREAK 4
`define UEF_BIT_ADDR 5

// Status event positions.
`define UEF_BIT_CLK_SETTLED 5
`define UEF_PIN_GROUP_W 4

// Mode control one positions.
`define UEF_BIT_IRQ_SEL 7
`define UEF_BIT_AUTO_DIR 4
`define UEF_BIT_RTS_TRI 3
`define UEF_BIT_TX_TRI 2
`define UEF_BIT_TX_DIS 1
`define UEF_BIT_RX_DIS 0

// Mode control two positions.
`define UEF_BIT_MULTIDROP 6
`define UEF_BIT_CHAR_MATCH 4
`define UEF_BIT_FIFO_CLR 1
`define UEF_BIT_SOFT_RST 0

// Reset values.
`define UEF_RST_SPCL_FLAGS 8'h00
`define UEF_RST_SPCL_EN 8'h00
`define UEF_RST_STS_EN 8'h00
`define UEF_RST_STS_FLAGS 8'h00
`define UEF_RST_MODE_CONTROL_ONE 8'h00
`define UEF_RST_MODE_CONTROL_TWO 8'h00

// Masks of implemented bits.
`define UEF_MASK_SPCL 8'h3F
`define UEF_MASK_STS_EN 8'h2F
`define UEF_MASK_MODE_CONTROL_ONE 8'h9F

// Timing: power-up hold of the interrupt pin.
`define UEF_CLK_KHZ 40000
`define UEF_POWERUP_NS 1000
`define UEF_POWERUP_CYC ((`UEF_POWERUP_NS * `UEF_CLK_KHZ + 999999) / 1000000)

`endif

/* File: uef_pkg.sv */
package uef_pkg;

  typedef enum logic [3:0] {
    UEF_DIR_IDLE = 4'h1,
    UEF_DIR_SETUP = 4'h2,
    UEF_DIR_SEND = 4'h4,
    UEF_DIR_HOLD = 4'h8
  } uef_dir_state_t;

  typedef logic [7:0] uef_reg_t;

endpackage

/* File: uef_pin_sync.sv */
`timescale 1ns/10ps
module uef_pin_sync #(
  parameter int W = 16
) (
  input wire logic clk, // Device clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [W-1:0] pin_in, // Asynchronous pin levels.
  output logic [W-1:0] pin_out // Levels after two flops.
);
  logic [W-1:0] meta_q;
  logic [W-1:0] stable_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[i] <= 1'b0;
          stable_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= pin_in[i];
          stable_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign pin_out = stable_q;
endmodule // uef_pin_sync

/* File: uef_dir_ctrl.sv */
`timescale 1ns/10ps
module uef_dir_ctrl (
  input wire logic clk, // Device clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic clr, // Synchronous channel reset.
  input wire logic auto_en, // Automatic direction control on.
  input wire logic fifo_has_data, // Transmit FIFO not empty.
  input wire logic shifter_busy, // Character on the wire.
  input wire logic bit_tick, // One pulse per bit time.
  input wire logic [3:0] setup_bits, // Bit times from RTS rise to send.
  input wire logic [3:0] hold_bits, // Bit times from empty to RTS fall.
  output logic rts_level, // Automatic RTS level.
  output logic send_ok, // Setup satisfied, may start a character.
  output logic empty_pulse // Transmitter fully emptied.
);
  uef_pkg::uef_dir_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic tx_empty;
  logic setup_done;
  logic hold_done;

  assign tx_empty = !fifo_has_data && !shifter_busy;
  assign setup_done = (cnt_q >= setup_bits);
  assign hold_done = (cnt_q >= hold_bits);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    empty_pulse = 1'b0;
    case (state_q)
      uef_pkg::UEF_DIR_IDLE: begin
        cnt_d = 4'h0;
        if (fifo_has_data) begin
          state_d = uef_pkg::UEF_DIR_SETUP;
        end
      end
      uef_pkg::UEF_DIR_SETUP: begin
        if (setup_done) begin
          state_d = uef_pkg::UEF_DIR_SEND;
        end else if (bit_tick) begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      uef_pkg::UEF_DIR_SEND: begin
        cnt_d = 4'h0;
        if (tx_empty) begin
          state_d = uef_pkg::UEF_DIR_HOLD;
        end
      end
      uef_pkg::UEF_DIR_HOLD: begin
        // Any activity, queued or on the wire, cancels the hold so the
        // empty event can only mark a transmitter that is fully idle.
        if (!tx_empty) begin
          state_d = uef_pkg::UEF_DIR_SEND;
        end else if (hold_done) begin
          state_d = uef_pkg::UEF_DIR_IDLE;
          empty_pulse = 1'b1;
        end else if (bit_tick) begin
          cnt_d = cnt_q + 4'h1;
        end
      end
      default: begin
        state_d = uef_pkg::UEF_DIR_IDLE;
        cnt_d = 4'h0;
      end
    endcase
    // Leaving automatic mode drops the machine at once.
    if (!auto_en) begin
      state_d = uef_pkg::UEF_DIR_IDLE;
      cnt_d = 4'h0;
      empty_pulse = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= uef_pkg::UEF_DIR_IDLE;
      cnt_q <= 4'h0;
    end else if (clr) begin
      state_q <= uef_pkg::UEF_DIR_IDLE;
      cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign rts_level = (state_q != uef_pkg::UEF_DIR_IDLE);
  assign send_ok = (state_q == uef_pkg::UEF_DIR_SEND);
endmodule // uef_dir_ctrl

/* File: uef_uart_flags.sv */
// Operation
// - In multidrop mode a received address character sets flag bit 5.
// - Receive line low beyond one character time sets break flag bit 4.
// - With matching on, resume/pause code hits set flag bits 0 to 3.
// - Reading the special-character flag register clears all its flags.
// - A special-character flag reaches its summary only when enabled.
// - Clock-settled status reaches status summary only while bit 5 enabled.
// - Each pin-change flag reaches status summary only when enabled.
// - Channel n watches pins 4n to 4n+3, lowest pin in bit 0.
// - Clock-settled status rises when settled, only with crystal source.
// - Clock-settled status survives reads; clears when clock disabled or in channel reset.
// - A pin level change sets its flag; status register read clears it.
// - After reset select bit is zero; interrupt pin low, then high.
// - With select bit set, interrupt pin shows pending interrupts.
// - Enabling automatic direction drives RTS low at once.
// - Automatic direction raises RTS with data queued, drops when empty.
// - RTS setup and hold follow delay register; empty raises an event.
// - Bit 3 floats the RTS pin, bit 2 floats the transmit pin.
// - Transmit disable finishes current character, keeps FIFO, idles high.
// - Automatic transmit-disable mode sets transmit disable when empty.
// - Receive disable stops new characters; FIFO contents stay readable.
// - Mode-two bit 6 selects nine-bit multidrop, no parity.
// - Mode-two bit 4 enables detection of four special characters.
// - Mode-two bit 0 holds the channel in reset until written zero.
`timescale 1ns/10ps
`include "uef_consts.svh"
module uef_uart_flags #(
  parameter int CHANNEL = 0
) (
  input wire logic CLK, // Device clock, 40 MHz.
  input wire logic RST_N, // Hardware reset, active low.
  input wire logic [7:0] REG_ADDR, // Register offset from host port.
  input wire logic REG_WR, // Write strobe, one cycle.
  input wire logic REG_RD, // Read strobe, one cycle.
  input wire logic [7:0] REG_WDATA, // Write data.
  output logic [7:0] REG_RDATA, // Read data, valid cycle after strobe.
  input wire logic RX_CHAR_VALID, // Receiver accepted a character.
  input wire logic [7:0] RX_CHAR, // Received character.
  input wire logic RX_NINTH_BIT, // Ninth bit, high marks an address.
  input wire logic RX_BREAK_DET, // Receiver saw a line break.
  input wire logic [7:0] RESUME_CODE_ONE, // First resume code.
  input wire logic [7:0] RESUME_CODE_TWO, // Second resume code.
  input wire logic [7:0] PAUSE_CODE_ONE, // First pause code.
  input wire logic [7:0] PAUSE_CODE_TWO, // Second pause code.
  input wire logic [15:0] GPIO_PINS, // Asynchronous general-purpose pins.
  input wire logic CLOCK_SETTLED, // Oscillator and PLL settled, async.
  input wire logic CLOCK_FROM_XTAL, // Crystal is the clock source.
  input wire logic CLOCK_ENABLED, // Reference clock enabled.
  input wire logic OTHER_IRQ_PENDING, // Other top interrupt bits pending.
  output logic SPECIAL_CHAR_SUMMARY, // Top interrupt bit 1.
  output logic STATUS_SUMMARY, // Top interrupt bit 2.
  output logic TX_EMPTY_EVENT, // Top interrupt bit 5, pulse.
  output logic IRQ_N, // Interrupt pin level, active low.
  output logic MULTIDROP_MODE, // Nine-bit mode, parity off.
  output logic CHAR_MATCH_ON, // Special-character detection on.
  output logic SOFT_RESET, // Channel reset level to FIFOs.
  output logic FIFO_CLEAR, // FIFO clear level.
  output logic RX_ENABLE, // Receiver may accept characters.
  output logic TX_START_OK, // Transmitter may start a character.
  input wire logic TXF_HAS_DATA, // Transmit FIFO not empty.
  input wire logic TX_SHIFTER_BUSY, // Transmit shifter busy.
  input wire logic TX_SERIAL, // Serial data from shifter.
  input wire logic BIT_TICK, // One pulse per bit time.
  input wire logic [3:0] HDPLX_SETUP, // Setup in bit times.
  input wire logic [3:0] HDPLX_HOLD, // Hold in bit times.
  input wire logic AUTO_TX_DISABLE, // Automatic transmit-disable mode.
  input wire logic RTS_MANUAL, // RTS level when not automatic.
  output logic TX_O, // Transmit pin level.
  output logic TX_OE, // Transmit pin driven.
  output logic RTS_O, // RTS pin level.
  output logic RTS_OE // RTS pin driven.
);
  localparam logic [5:0] POWERUP_CYC = 6'(`UEF_POWERUP_CYC);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [7:0] spcl_q, spcl_d;
  logic [7:0] spcl_en_q;
  logic [7:0] sts_en_q;
  logic [3:0] pin_evt_q, pin_evt_d;
  logic clk_ok_q, clk_ok_d;
  logic [7:0] mode_control_one_q;
  logic [7:0] mode_control_two_q;
  logic [7:0] rdata_q, rdata_d;
  logic [3:0] pin_prev_q;
  logic [5:0] pwr_cnt_q;
  logic pwr_done_q;
  logic [15:0] gpio_s;
  logic [0:0] misc_s;
  logic [2:0] prime_q;
  logic [3:0] my_pins;
  logic [3:0] pin_change;
  logic [5:0] spcl_set;
  logic sts_rd;
  logic spcl_rd;
  logic soft_rst;
  logic wr_spcl_en;
  logic wr_sts_en;
  logic wr_mode_control_one;
  logic wr_mode_control_two;
  logic rts_auto;
  logic dir_send_ok;
  logic dir_empty;
  logic tx_empty;
  logic [7:0] sts_view;
  logic irq_any;

  uef_pin_sync #(.W(16)) u_gpio_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .pin_in(GPIO_PINS),
    .pin_out(gpio_s)
  );

  // Clock-settled arrives from the analog side.
  uef_pin_sync #(.W(1)) u_clk_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .pin_in(CLOCK_SETTLED),
    .pin_out(misc_s)
  );

  assign soft_rst = mode_control_two_q[`UEF_BIT_SOFT_RST];
  assign wr_spcl_en = REG_WR && hit(REG_ADDR, `UEF_OFS_SPCL_EN);
  assign wr_sts_en = REG_WR && hit(REG_ADDR, `UEF_OFS_STS_EN);
  assign wr_mode_control_one = REG_WR && hit(REG_ADDR, `UEF_OFS_MODE_CONTROL_ONE);
  assign wr_mode_control_two = REG_WR && hit(REG_ADDR, `UEF_OFS_MODE_CONTROL_TWO);
  assign spcl_rd = REG_RD && hit(REG_ADDR, `UEF_OFS_SPCL_FLAGS);
  assign sts_rd = REG_RD && hit(REG_ADDR, `UEF_OFS_STS_FLAGS);

  // Special-character events from the receiver.
  assign spcl_set[`UEF_BIT_ADDR] = RX_CHAR_VALID && RX_NINTH_BIT
    && mode_control_two_q[`UEF_BIT_MULTIDROP];
  assign spcl_set[`UEF_BIT_BREAK] = RX_BREAK_DET;
  assign spcl_set[`UEF_BIT_RESUME1] = RX_CHAR_VALID && CHAR_MATCH_ON
    && (RX_CHAR == RESUME_CODE_ONE);
  assign spcl_set[`UEF_BIT_RESUME2] = RX_CHAR_VALID && CHAR_MATCH_ON
    && (RX_CHAR == RESUME_CODE_TWO);
  assign spcl_set[`UEF_BIT_PAUSE1] = RX_CHAR_VALID && CHAR_MATCH_ON
    && (RX_CHAR == PAUSE_CODE_ONE);
  assign spcl_set[`UEF_BIT_PAUSE2] = RX_CHAR_VALID && CHAR_MATCH_ON
    && (RX_CHAR == PAUSE_CODE_TWO);

  // Set wins over the clearing read so no event slips between them.
  assign spcl_d = ((spcl_rd ? 8'h00 : spcl_q) | {2'h0, spcl_set})
    & `UEF_MASK_SPCL;

  assign my_pins = gpio_s[CHANNEL*`UEF_PIN_GROUP_W +: `UEF_PIN_GROUP_W];
  assign pin_change = (my_pins ^ pin_prev_q) & {4{prime_q[2]}};
  assign pin_evt_d = (sts_rd ? 4'h0 : pin_evt_q) | pin_change;

  // Clock-settled is not touched by reads; a stopped clock or either reset drops it.
  assign clk_ok_d = !CLOCK_ENABLED ? 1'b0
    : (clk_ok_q | (misc_s[0] & CLOCK_FROM_XTAL));

  assign sts_view = {2'h0, clk_ok_q, 1'b0, pin_evt_q};

  always_comb begin
    case (REG_ADDR)
      `UEF_OFS_SPCL_EN: rdata_d = spcl_en_q;
      `UEF_OFS_SPCL_FLAGS: rdata_d = spcl_q;
      `UEF_OFS_STS_EN: rdata_d = sts_en_q;
      `UEF_OFS_STS_FLAGS: rdata_d = sts_view;
      `UEF_OFS_MODE_CONTROL_ONE: rdata_d = mode_control_one_q;
      `UEF_OFS_MODE_CONTROL_TWO: rdata_d = mode_control_two_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Hardware reset and channel reset clear the same registers.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      spcl_q <= `UEF_RST_SPCL_FLAGS;
      spcl_en_q <= `UEF_RST_SPCL_EN;
      sts_en_q <= `UEF_RST_STS_EN;
      pin_evt_q <= 4'h0;
      clk_ok_q <= 1'b0;
    end else if (soft_rst) begin
      spcl_q <= `UEF_RST_SPCL_FLAGS;
      spcl_en_q <= `UEF_RST_SPCL_EN;
      sts_en_q <= `UEF_RST_STS_EN;
      pin_evt_q <= 4'h0;
      clk_ok_q <= 1'b0;
    end else begin
      spcl_q <= spcl_d;
      pin_evt_q <= pin_evt_d;
      clk_ok_q <= clk_ok_d;
      if (wr_spcl_en) begin
        spcl_en_q <= REG_WDATA & `UEF_MASK_SPCL;
      end
      if (wr_sts_en) begin
        sts_en_q <= REG_WDATA & `UEF_MASK_STS_EN;
      end
    end
  end

  // Pins that idle high would look like a change while the synchroniser
  // fills after hardware reset, so changes are ignored for three edges.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prime_q <= 3'h0;
    end else begin
      prime_q <= {prime_q[1:0], 1'b1};
    end
  end

  // The previous pin levels keep following the pins in channel reset, so
  // leaving it does not report a stale change.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_prev_q <= 4'h0;
    end else begin
      pin_prev_q <= my_pins;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_control_one_q <= `UEF_RST_MODE_CONTROL_ONE;
    end else if (soft_rst) begin
      mode_control_one_q <= `UEF_RST_MODE_CONTROL_ONE;
    end else if (wr_mode_control_one) begin
      mode_control_one_q <= REG_WDATA & `UEF_MASK_MODE_CONTROL_ONE;
    end else if (AUTO_TX_DISABLE && tx_empty) begin
      mode_control_one_q[`UEF_BIT_TX_DIS] <= 1'b1;
    end
  end

  // Mode two stays writable in channel reset so the host can release it.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_control_two_q <= `UEF_RST_MODE_CONTROL_TWO;
    end else if (wr_mode_control_two) begin
      mode_control_two_q <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 8'h00;
    end else if (REG_RD) begin
      rdata_q <= rdata_d;
    end
  end

  // Power-up timer restarts on either reset.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwr_cnt_q <= 6'h00;
      pwr_done_q <= 1'b0;
    end else if (soft_rst) begin
      pwr_cnt_q <= 6'h00;
      pwr_done_q <= 1'b0;
    end else if (!pwr_done_q) begin
      pwr_cnt_q <= pwr_cnt_q + 6'h01;
      pwr_done_q <= (pwr_cnt_q + 6'h01 >= POWERUP_CYC);
    end
  end

  uef_dir_ctrl u_dir (
    .clk(CLK),
    .rst_n(RST_N),
    .clr(soft_rst),
    .auto_en(mode_control_one_q[`UEF_BIT_AUTO_DIR]),
    .fifo_has_data(TXF_HAS_DATA),
    .shifter_busy(TX_SHIFTER_BUSY),
    .bit_tick(BIT_TICK),
    .setup_bits(HDPLX_SETUP),
    .hold_bits(HDPLX_HOLD),
    .rts_level(rts_auto),
    .send_ok(dir_send_ok),
    .empty_pulse(dir_empty)
  );

  assign tx_empty = !TXF_HAS_DATA && !TX_SHIFTER_BUSY;
  assign REG_RDATA = rdata_q;

  assign SPECIAL_CHAR_SUMMARY = |(spcl_q & spcl_en_q);
  assign STATUS_SUMMARY = (clk_ok_q & sts_en_q[`UEF_BIT_CLK_SETTLED])
    | (|(pin_evt_q & sts_en_q[3:0]));
  assign TX_EMPTY_EVENT = dir_empty;
  assign irq_any = SPECIAL_CHAR_SUMMARY || STATUS_SUMMARY
    || TX_EMPTY_EVENT || OTHER_IRQ_PENDING;
  // Before the select bit is set the pin only signals power-up done.
  assign IRQ_N = mode_control_one_q[`UEF_BIT_IRQ_SEL] ? !irq_any
    : pwr_done_q;

  assign MULTIDROP_MODE = mode_control_two_q[`UEF_BIT_MULTIDROP];
  assign CHAR_MATCH_ON = mode_control_two_q[`UEF_BIT_CHAR_MATCH];
  assign SOFT_RESET = soft_rst;
  assign FIFO_CLEAR = mode_control_two_q[`UEF_BIT_FIFO_CLR] | soft_rst;
  assign RX_ENABLE = !mode_control_one_q[`UEF_BIT_RX_DIS] && !soft_rst;

  // Disable only blocks new starts; a character in flight completes.
  assign TX_START_OK = !mode_control_one_q[`UEF_BIT_TX_DIS] && !soft_rst
    && (!mode_control_one_q[`UEF_BIT_AUTO_DIR] || dir_send_ok);
  assign TX_O = TX_SHIFTER_BUSY ? TX_SERIAL : 1'b1;
  assign TX_OE = !mode_control_one_q[`UEF_BIT_TX_TRI];
  assign RTS_O = mode_control_one_q[`UEF_BIT_AUTO_DIR] ? rts_auto : RTS_MANUAL;
  assign RTS_OE = !mode_control_one_q[`UEF_BIT_RTS_TRI];
endmodule // uef_uart_flags

/* File: uef_host_model.sv */
`timescale 1ns/10ps
module uef_host_model (
  input wire logic clk, // Device clock.
  output logic [7:0] reg_addr, // Register offset.
  output logic reg_wr, // Write strobe.
  output logic reg_rd, // Read strobe.
  output logic [7:0] reg_wdata, // Write data.
  input wire logic [7:0] reg_rdata // Read data.
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  // Strobes last one cycle; the data lines then carry a changing pattern,
  // so a design that samples them late picks up garbage.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule // uef_host_model

/* File: uef_uart_flags_asserts.sv */
`timescale 1ns/10ps
module uef_uart_flags_asserts (
  input wire logic CLK, // Device clock.
  input wire logic RST_N, // Reset, active low.
  input wire logic [7:0] REG_ADDR, // Register offset.
  input wire logic REG_WR, // Write strobe.
  input wire logic REG_RD, // Read strobe.
  input wire logic [7:0] REG_WDATA, // Write data.
  input wire logic RX_CHAR_VALID, // Character accepted.
  input wire logic RX_BREAK_DET, // Break seen.
  input wire logic TXF_HAS_DATA, // Transmit FIFO not empty.
  input wire logic TX_SHIFTER_BUSY, // Shifter busy.
  input wire logic SPECIAL_CHAR_SUMMARY, // Special summary.
  input wire logic TX_EMPTY_EVENT, // Empty pulse.
  input wire logic IRQ_N, // Interrupt pin.
  input wire logic MULTIDROP_MODE, // Nine-bit mode.
  input wire logic CHAR_MATCH_ON, // Matching on.
  input wire logic SOFT_RESET, // Channel reset.
  input wire logic RX_ENABLE, // Receiver enabled.
  input wire logic TX_START_OK, // May start a character.
  input wire logic TX_OE, // Transmit pin driven.
  input wire logic RTS_OE // RTS pin driven.
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  irq_powerup_a: assert property (
    $rose(RST_N) |-> !IRQ_N [*8] ##[28:36] IRQ_N)
    else $error("interrupt pin power-up timing wrong");
  spcl_read_clear_a: assert property (
    REG_RD && REG_ADDR == 8'h06 && !RX_CHAR_VALID && !RX_BREAK_DET
    |=> !SPECIAL_CHAR_SUMMARY)
    else $error("special flags survived a read");
  empty_pulse_cause_a: assert property (
    TX_EMPTY_EVENT |-> !TXF_HAS_DATA && !TX_SHIFTER_BUSY)
    else $error("empty pulse while transmitter busy");
  empty_pulse_once_a: assert property (
    TX_EMPTY_EVENT |=> !TX_EMPTY_EVENT)
    else $error("empty pulse longer than one cycle");
  tristate_write_a: assert property (
    REG_WR && REG_ADDR == 8'h09 && !SOFT_RESET
    |=> RTS_OE == !$past(REG_WDATA[3]) && TX_OE == !$past(REG_WDATA[2]))
    else $error("pin drive does not follow mode one");
  rx_disable_a: assert property (
    REG_WR && REG_ADDR == 8'h09 && !SOFT_RESET
    |=> RX_ENABLE == !$past(REG_WDATA[0]))
    else $error("receiver enable does not follow mode one");
  tx_disable_a: assert property (
    REG_WR && REG_ADDR == 8'h09 && REG_WDATA[1] |=> !TX_START_OK)
    else $error("transmit start allowed while disabled");
  soft_reset_hold_a: assert property (
    SOFT_RESET ##1 SOFT_RESET |-> RTS_OE && TX_OE && !TX_START_OK)
    else $error("channel reset left mode one active");
  mode_two_bits_a: assert property (
    REG_WR && REG_ADDR == 8'h0A |=> MULTIDROP_MODE == $past(REG_WDATA[6])
    && CHAR_MATCH_ON == $past(REG_WDATA[4]))
    else $error("mode two bits not applied");
endmodule // uef_uart_flags_asserts

/* File: uef_uart_flags_bench.sv */
`timescale 1ns/10ps
module uef_uart_flags_bench;
  logic clk, rst_n, rd, wr, rx_v, rx_n9, brk, settled, xtal, clk_en;
  logic other, has_data, busy, tick, auto_txd, rts_man, seen;
  logic [7:0] addr, wdata, rdata, codes [4], d;
  logic [15:0] gpio;
  logic [7:0] rx_c;
  logic [3:0] hsetup;
  logic [1:0] tcnt;
  logic spcl_sum, sts_sum, empty_ev, irq_n, md, cm, srst, fclr, rx_en;
  logic start_ok, tx_o, tx_oe, rts_o, rts_oe;
  int bad_count, comparisons;

  uef_uart_flags #(.CHANNEL(1)) u_dut (.CLK(clk), .RST_N(rst_n),
    .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .RX_CHAR_VALID(rx_v), .RX_CHAR(rx_c),
    .RX_NINTH_BIT(rx_n9), .RX_BREAK_DET(brk), .RESUME_CODE_ONE(codes[0]),
    .RESUME_CODE_TWO(codes[1]), .PAUSE_CODE_ONE(codes[2]),
    .PAUSE_CODE_TWO(codes[3]), .GPIO_PINS(gpio), .CLOCK_SETTLED(settled),
    .CLOCK_FROM_XTAL(xtal), .CLOCK_ENABLED(clk_en),
    .OTHER_IRQ_PENDING(other), .SPECIAL_CHAR_SUMMARY(spcl_sum),
    .STATUS_SUMMARY(sts_sum), .TX_EMPTY_EVENT(empty_ev), .IRQ_N(irq_n),
    .MULTIDROP_MODE(md), .CHAR_MATCH_ON(cm), .SOFT_RESET(srst),
    .FIFO_CLEAR(fclr), .RX_ENABLE(rx_en), .TX_START_OK(start_ok),
    .TXF_HAS_DATA(has_data), .TX_SHIFTER_BUSY(busy), .TX_SERIAL(busy),
    .BIT_TICK(tick), .HDPLX_SETUP(hsetup), .HDPLX_HOLD(4'h2),
    .AUTO_TX_DISABLE(auto_txd), .RTS_MANUAL(rts_man), .TX_O(tx_o),
    .TX_OE(tx_oe), .RTS_O(rts_o), .RTS_OE(rts_oe));
  uef_host_model u_host (.clk(clk), .reg_addr(addr), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // One bit time is four device clocks.
  always @(negedge clk) begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, d);
    chk8(d, exp);
  endtask
  task automatic chr(input logic [7:0] c, input logic n9);
    @(negedge clk);
    rx_c = c;
    rx_n9 = n9;
    rx_v = 1'b1;
    @(negedge clk);
    rx_v = 1'b0;
    rx_c = ~c;
  endtask
  task automatic pulse_brk();
    @(negedge clk);
    brk = 1'b1;
    @(negedge clk);
    brk = 1'b0;
  endtask
  task automatic settle();
    repeat (5) @(negedge clk);
  endtask

  task automatic t_reset();
    chk1(irq_n, 1'b0);
    repeat (45) @(negedge clk);
    chk1(irq_n, 1'b1);
    for (int a = 5; a <= 10; a++) rdc(8'(a), 8'h00);
    rdc(8'h30, 8'h00);
  endtask

  task automatic t_special();
    u_host.wr(8'h0A, 8'h50);
    chk8({md, cm}, 8'h03);
    for (int i = 0; i < 4; i++) chr(codes[i], 1'b0);
    chr(8'h55, 1'b1);
    pulse_brk();
    chk1(spcl_sum, 1'b0);
    u_host.wr(8'h05, 8'h20);
    chk1(spcl_sum, 1'b1);
    rdc(8'h06, 8'h3F);
    chk1(spcl_sum, 1'b0);
    rdc(8'h06, 8'h00);
    u_host.wr(8'h0A, 8'h00);
    chr(codes[0], 1'b1);
    rdc(8'h06, 8'h00);
    fork
      u_host.rd(8'h06, d);
      pulse_brk();
    join
    rdc(8'h06, 8'h10);
  endtask

  task automatic t_status();
    gpio = 16'h000F;
    settle();
    rdc(8'h08, 8'h00);
    gpio = 16'h00AF;
    settle();
    rdc(8'h08, 8'h0A);
    gpio = 16'h00FF;
    settle();
    chk1(sts_sum, 1'b0);
    u_host.wr(8'h07, 8'h01);
    chk1(sts_sum, 1'b1);
    rdc(8'h08, 8'h05);
    chk1(sts_sum, 1'b0);
    settled = 1'b1;
    settle();
    rdc(8'h08, 8'h00);
    xtal = 1'b1;
    settle();
    rdc(8'h08, 8'h20);
    rdc(8'h08, 8'h20);
    u_host.wr(8'h07, 8'h20);
    chk1(sts_sum, 1'b1);
    u_host.wr(8'h07, 8'h00);
    chk1(sts_sum, 1'b0);
    clk_en = 1'b0;
    settle();
    rdc(8'h08, 8'h00);
    clk_en = 1'b1;
  endtask

  task automatic t_mode();
    u_host.wr(8'h05, 8'h10);
    u_host.wr(8'h09, 8'h80);
    chk1(irq_n, 1'b1);
    pulse_brk();
    chk1(irq_n, 1'b0);
    rdc(8'h06, 8'h10);
    chk1(irq_n, 1'b1);
    u_host.wr(8'h09, 8'h0C);
    chk8({rts_oe, tx_oe}, 8'h00);
    u_host.wr(8'h09, 8'h03);
    chk8({rx_en, start_ok, tx_o}, 8'h01);
    u_host.wr(8'h09, 8'h10);
    chk1(rts_o, 1'b0);
    has_data = 1'b1;
    busy = 1'b1;
    @(negedge clk);
    chk1(rts_o, 1'b1);
    @(negedge clk);
    chk1(start_ok, 1'b1);
    has_data = 1'b0;
    busy = 1'b0;
    seen = 1'b0;
    for (int i = 0; i < 40 && rts_o; i++) begin
      @(negedge clk);
      seen = seen | empty_ev;
    end
    chk8({seen, rts_o}, 8'h02);
    hsetup = 4'h1;
    has_data = 1'b1;
    repeat (2) @(negedge clk);
    chk8({rts_o, start_ok}, 8'h02);
    repeat (6) @(negedge clk);
    chk8({rts_o, start_ok}, 8'h03);
    has_data = 1'b0;
    auto_txd = 1'b1;
    settle();
    rdc(8'h09, 8'h12);
    auto_txd = 1'b0;
    u_host.wr(8'h0A, 8'h01);
    chk8({srst, fclr}, 8'h03);
    rdc(8'h09, 8'h00);
    chk1(irq_n, 1'b0);
    rdc(8'h0A, 8'h01);
    u_host.wr(8'h0A, 8'h00);
    chk8({srst, fclr}, 8'h00);
    repeat (45) @(negedge clk);
    chk1(irq_n, 1'b1);
    u_host.wr(8'h0A, 8'h02);
    chk8({srst, fclr}, 8'h01);
    u_host.wr(8'h0A, 8'h00);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    results();
  end

  initial begin
    {rst_n, rx_v, rx_n9, brk, settled, xtal, other, tcnt} = '0;
    {has_data, busy, tick, auto_txd} = '0;
    {clk_en, rts_man} = 2'b11;
    rx_c = 8'h00;
    hsetup = 4'h0;
    gpio = 16'h0000;
    codes = '{8'h11, 8'h13, 8'h91, 8'h93};
    bad_count = 0;
    comparisons = 0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_special();
    t_status();
    t_mode();
    results();
  end
endmodule // uef_uart_flags_bench

bind uef_uart_flags uef_uart_flags_asserts u_chk (.CLK(CLK), .RST_N(RST_N),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_WDATA(REG_WDATA), .RX_CHAR_VALID(RX_CHAR_VALID),
  .RX_BREAK_DET(RX_BREAK_DET), .TXF_HAS_DATA(TXF_HAS_DATA),
  .TX_SHIFTER_BUSY(TX_SHIFTER_BUSY),
  .SPECIAL_CHAR_SUMMARY(SPECIAL_CHAR_SUMMARY),
  .TX_EMPTY_EVENT(TX_EMPTY_EVENT), .IRQ_N(IRQ_N),
  .MULTIDROP_MODE(MULTIDROP_MODE), .CHAR_MATCH_ON(CHAR_MATCH_ON),
  .SOFT_RESET(SOFT_RESET), .RX_ENABLE(RX_ENABLE), .TX_START_OK(TX_START_OK),
  .TX_OE(TX_OE), .RTS_OE(RTS_OE));
